// ### rtl/spp_pkg.sv
/*
 serial peripheral port: register offsets, status bit positions, reset values,
 control register layout, engine states and shared helper functions.
 assumes a 32-bit apb slave with word-aligned registers.
*/
package spp_pkg;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [11:0] SPP_STAT_OFS = 12'h000;
   localparam logic [11:0] SPP_CTRL_OFS = 12'h004;
   localparam logic [11:0] SPP_BUF_OFS  = 12'h008;

   // ------------------------------------------------------------------
   // port_status bit positions
   // ------------------------------------------------------------------
   localparam int SPP_ST_ENABLE    = 15;
   localparam int SPP_ST_IDLE_STOP = 13;
   localparam int SPP_ST_IRQ_EN    = 9;
   localparam int SPP_ST_IRQ_FLAG  = 8;
   localparam int SPP_ST_ROV       = 6;
   localparam int SPP_ST_TBF       = 1;
   localparam int SPP_ST_RBF       = 0;

   // ------------------------------------------------------------------
   // reset values and widths
   // ------------------------------------------------------------------
   localparam logic [15:0] SPP_CTRL_RST = 16'h0000;
   localparam logic [15:0] SPP_WORD_RST = 16'h0000;
   localparam logic [4:0]  SPP_BITS_8   = 5'h08;
   localparam logic [4:0]  SPP_BITS_16  = 5'h10;

   // ------------------------------------------------------------------
   // port_control layout
   // ------------------------------------------------------------------
   typedef struct packed {
      logic       rsv15;
      logic       framed_enable;
      logic       frame_sync_direction;
      logic       rsv12;
      logic       out_pin_disable;
      logic       word_size_select;
      logic       sample_late;
      logic       clock_edge_select;
      logic       select_pin_enable;
      logic       clock_idle_polarity;
      logic       master_enable;
      logic [2:0] secondary_prescale;
      logic [1:0] primary_prescale;
   } spp_ctrl_t;

   typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_DATA, ST_TAIL} spp_state_t;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic logic spp_word_msb(input logic [15:0] w, input logic w16);
      return w16 ? w[15] : w[7];
   endfunction

   // half period of the shift clock in module clocks, minus one
   function automatic logic [9:0] spp_presc_limit(input logic [1:0] p, input logic [2:0] s);
      logic [9:0] pri;
      logic [9:0] sec;
      pri = 10'h001 << {p ^ 2'h3, 1'b0};
      sec = 10'h008 - {7'h00, s};
      return 10'(pri * sec) - 10'h001;
   endfunction

endpackage

// ### rtl/spp_port.sv
/*
 serial peripheral port: apb register slave, shift engine for master and
 slave, prescaled shift clock, framed mode and select resynchronisation.
 assumes pins are synchronous to ref_clk; a pad ring resolves the enables.
*/
// Notes on behaviour
// - transfer is 8 or 16 shift pulses
// - completion sets flag, interrupt when enabled
// - finished word copied into receive buffer
// - unread buffer: set overflow, drop word
// - overflow freezes shifting until buffer read
// - pending transmit word loads next transfer
// - one address: write transmit, read receive
// - master clocks out, starts on write
// - master completion at last bit midpoint
// - slave shifts on external clock pulses
// - shift clock from two-stage prescaler
// - edge select picks output change edge
// - polarity bit sets clock idle level
// - control bit 10 picks word size
// - word size change resets the port
// - out from bit 7 or 15, in bit 0
// - disable bit releases serial output
// - framed mode turns select into sync
// - sync one clock, data follows after
// - select high stops slave, releases output
// - select high resets counters and state
// - sleep aborts transfer, keeps registers
// - idle stop bit halts during idle
`timescale 1ns/1ps
`default_nettype none

module spp_port
   import spp_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        sleep_req,
   input  wire logic        idle_req,
   input  wire logic        serial_in_pin,
   output logic             serial_out_pin,
   output logic             serial_out_oe,
   input  wire logic        shift_clock_pin,
   output logic             shift_clock_level,
   output logic             shift_clock_oe,
   input  wire logic        select_n_pin,
   output logic             frame_sync_pulse,
   output logic             frame_sync_oe,
   output logic             port_irq
);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   spp_ctrl_t   ctrl_q,    ctrl_d;
   spp_state_t  st_q,      st_d;
   logic        en_q,      en_d;
   logic        sidl_q,    sidl_d;
   logic        ie_q,      ie_d;
   logic        irqf_q,    irqf_d;
   logic        rov_q,     rov_d;
   logic        rbf_q,     rbf_d;
   logic        tbf_q,     tbf_d;
   logic [15:0] txb_q,     txb_d;
   logic [15:0] rxb_q,     rxb_d;
   logic [15:0] sr_q,      sr_d;
   logic [4:0]  cnt_q,     cnt_d;
   logic [9:0]  div_q,     div_d;
   logic        phase_q,   phase_d;
   logic        prev_q,    prev_d;
   logic        sdo_q;
   logic        sdo_d;
   logic        sck_q,     sck_d;
   logic        sck_oe_q,  sck_oe_d;
   logic        sdo_oe_q,  sdo_oe_d;
   logic        fs_q,      fs_d;
   logic        fs_oe_q,   fs_oe_d;
   logic        irq_q,     irq_d;
   logic [31:0] prdata_q,  prdata_d;
   logic        pready_q,  pready_d;
   logic        pslverr_q, pslverr_d;

   logic        acc, wr, rbuf, wbuf, hit_any;
   logic        halt, freeze, abort, selected, fs_level, start;
   logic        lead, trail, chg_ev, smp_ev, done;
   logic [4:0]  nbits;
   logic [15:0] shifted;

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb
   begin
      ctrl_d   = ctrl_q;
      st_d     = st_q;
      en_d     = en_q;
      sidl_d   = sidl_q;
      ie_d     = ie_q;
      irqf_d   = irqf_q;
      rov_d    = rov_q;
      rbf_d    = rbf_q;
      tbf_d    = tbf_q;
      txb_d    = txb_q;
      rxb_d    = rxb_q;
      sr_d     = sr_q;
      cnt_d    = cnt_q;
      div_d    = div_q;
      phase_d  = phase_q;
      sdo_d    = sdo_q;
      lead     = 1'b0;
      trail    = 1'b0;
      done     = 1'b0;
      start    = 1'b0;

      // apb decode, access completes on the ready edge
      acc     = psel & penable & pready_q;
      wr      = acc & pwrite;
      wbuf    = wr & (paddr == SPP_BUF_OFS);
      rbuf    = acc & ~pwrite & (paddr == SPP_BUF_OFS);
      hit_any = (paddr == SPP_STAT_OFS) | (paddr == SPP_CTRL_OFS) |
                (paddr == SPP_BUF_OFS);

      nbits    = ctrl_q.word_size_select ? SPP_BITS_16 : SPP_BITS_8;
      freeze   = sidl_q & idle_req;
      selected = ~ctrl_q.select_pin_enable | ~select_n_pin;
      fs_level = ctrl_q.frame_sync_direction ? select_n_pin : 1'b1;
      halt     = freeze | rov_q;
      abort    = ~en_q | sleep_req;
      if (!ctrl_q.master_enable && !ctrl_q.framed_enable && !selected)
      begin
         abort = 1'b1;
      end

      // software reads of the buffer release the receive side
      if (rbuf)
      begin
         rbf_d = 1'b0;
         rov_d = 1'b0;
      end

      // shift clock edges: prescaled generator or external pin
      prev_d = shift_clock_pin ^ ctrl_q.clock_idle_polarity;
      if (ctrl_q.master_enable)
      begin
         if (st_q != ST_IDLE && !halt)
         begin
            if (div_q == spp_presc_limit(ctrl_q.primary_prescale,
                                         ctrl_q.secondary_prescale))
            begin
               div_d   = 10'h000;
               phase_d = ~phase_q;
               lead    = ~phase_q;
               trail   = phase_q;
            end
            else
            begin
               div_d = div_q + 10'h001;
            end
         end
      end
      else if (st_q != ST_IDLE && !halt)
      begin
         lead  = prev_d & ~prev_q;
         trail = ~prev_d & prev_q;
      end
      chg_ev  = ctrl_q.clock_edge_select ? trail : lead;
      smp_ev  = ctrl_q.clock_edge_select ? lead : trail;
      shifted = {sr_q[14:0], serial_in_pin};

      unique case (st_q)
         ST_IDLE:
         begin
            div_d   = 10'h000;
            phase_d = 1'b0;
            cnt_d   = 5'h00;
            if (ctrl_q.master_enable)
            begin
               start = tbf_q;
            end
            else
            begin
               start = ctrl_q.framed_enable | selected;
            end
            start = start & en_q & ~freeze & ~rov_q & ~sleep_req;
            if (start)
            begin
               if (tbf_q)
               begin
                  sr_d  = txb_q;
                  sdo_d = spp_word_msb(txb_q, ctrl_q.word_size_select);
                  tbf_d = 1'b0;
               end
               else
               begin
                  sdo_d = spp_word_msb(sr_q, ctrl_q.word_size_select);
               end
               st_d = ctrl_q.framed_enable ? ST_SYNC : ST_DATA;
            end
         end
         ST_SYNC:
         begin
            if (trail && fs_level)
            begin
               st_d = ST_DATA;
            end
         end
         ST_DATA:
         begin
            if (chg_ev)
            begin
               sdo_d = spp_word_msb(sr_q, ctrl_q.word_size_select);
            end
            if (smp_ev)
            begin
               sr_d  = shifted;
               cnt_d = cnt_q + 5'h01;
               if (cnt_q == nbits - 5'h01)
               begin
                  done  = 1'b1;
                  cnt_d = 5'h00;
                  st_d  = ctrl_q.clock_edge_select ? ST_TAIL : ST_IDLE;
               end
            end
         end
         ST_TAIL:
         begin
            if (trail)
            begin
               st_d = ST_IDLE;
            end
         end
      endcase

      // end of word: flag, then copy unless the buffer is still full
      if (done)
      begin
         irqf_d = 1'b1;
         if (rbf_q && !rbuf)
         begin
            rov_d = 1'b1;
         end
         else
         begin
            rxb_d = ctrl_q.word_size_select ? shifted
                                            : {8'h00, shifted[7:0]};
            rbf_d = 1'b1;
         end
      end

      // register writes; hardware set of the irq flag wins over software clear
      if (wr && paddr == SPP_STAT_OFS)
      begin
         en_d   = pwdata[SPP_ST_ENABLE];
         sidl_d = pwdata[SPP_ST_IDLE_STOP];
         ie_d   = pwdata[SPP_ST_IRQ_EN];
         irqf_d = (irqf_q & pwdata[SPP_ST_IRQ_FLAG]) | done;
      end
      if (wr && paddr == SPP_CTRL_OFS)
      begin
         ctrl_d       = spp_ctrl_t'(pwdata[15:0]);
         ctrl_d.rsv15 = 1'b0;
         ctrl_d.rsv12 = 1'b0;
         if (ctrl_d.word_size_select != ctrl_q.word_size_select)
         begin
            abort = 1'b1;
            tbf_d = 1'b0;
            rbf_d = 1'b0;
            rov_d = 1'b0;
         end
      end
      if (wbuf)
      begin
         txb_d = pwdata[15:0];
         tbf_d = 1'b1;
      end

      if (abort)
      begin
         st_d    = ST_IDLE;
         cnt_d   = 5'h00;
         div_d   = 10'h000;
         phase_d = 1'b0;
      end

      // pin drivers
      sck_d    = ctrl_q.clock_idle_polarity ^ (ctrl_q.master_enable & phase_d);
      sck_oe_d = en_q & ctrl_q.master_enable;
      sdo_oe_d = en_q & ~ctrl_q.out_pin_disable &
                 (ctrl_q.master_enable | ctrl_q.framed_enable | selected);
      fs_oe_d  = en_q & ctrl_q.framed_enable & ~ctrl_q.frame_sync_direction;
      fs_d     = fs_oe_d & (st_d == ST_SYNC);
      irq_d    = irqf_d & ie_d;

      // apb answer one cycle after the access phase opens
      pready_d  = psel & penable & ~pready_q;
      pslverr_d = pready_d & ~hit_any;
      prdata_d  = 32'h0000_0000;
      if (pready_d && !pwrite)
      begin
         if (paddr == SPP_STAT_OFS)
         begin
            prdata_d[SPP_ST_ENABLE]    = en_q;
            prdata_d[SPP_ST_IDLE_STOP] = sidl_q;
            prdata_d[SPP_ST_IRQ_EN]    = ie_q;
            prdata_d[SPP_ST_IRQ_FLAG]  = irqf_q;
            prdata_d[SPP_ST_ROV]       = rov_q;
            prdata_d[SPP_ST_TBF]       = tbf_q;
            prdata_d[SPP_ST_RBF]       = rbf_q;
         end
         else if (paddr == SPP_CTRL_OFS)
         begin
            prdata_d[15:0] = ctrl_q;
         end
         else if (paddr == SPP_BUF_OFS)
         begin
            prdata_d[15:0] = rxb_q;
         end
      end
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_q    <= spp_ctrl_t'(SPP_CTRL_RST);
         st_q      <= ST_IDLE;
         en_q      <= 1'b0;
         sidl_q    <= 1'b0;
         ie_q      <= 1'b0;
         irqf_q    <= 1'b0;
         rov_q     <= 1'b0;
         rbf_q     <= 1'b0;
         tbf_q     <= 1'b0;
         txb_q     <= SPP_WORD_RST;
         rxb_q     <= SPP_WORD_RST;
         sr_q      <= SPP_WORD_RST;
         cnt_q     <= 5'h00;
         div_q     <= 10'h000;
         phase_q   <= 1'b0;
         prev_q    <= 1'b0;
         sdo_q     <= 1'b0;
         sck_q     <= 1'b0;
         sck_oe_q  <= 1'b0;
         sdo_oe_q  <= 1'b0;
         fs_q      <= 1'b0;
         fs_oe_q   <= 1'b0;
         irq_q     <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else
      begin
         ctrl_q    <= ctrl_d;
         st_q      <= st_d;
         en_q      <= en_d;
         sidl_q    <= sidl_d;
         ie_q      <= ie_d;
         irqf_q    <= irqf_d;
         rov_q     <= rov_d;
         rbf_q     <= rbf_d;
         tbf_q     <= tbf_d;
         txb_q     <= txb_d;
         rxb_q     <= rxb_d;
         sr_q      <= sr_d;
         cnt_q     <= cnt_d;
         div_q     <= div_d;
         phase_q   <= phase_d;
         prev_q    <= prev_d;
         sdo_q     <= sdo_d;
         sck_q     <= sck_d;
         sck_oe_q  <= sck_oe_d;
         sdo_oe_q  <= sdo_oe_d;
         fs_q      <= fs_d;
         fs_oe_q   <= fs_oe_d;
         irq_q     <= irq_d;
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign prdata            = prdata_q;
   assign pready            = pready_q;
   assign pslverr           = pslverr_q;
   assign serial_out_pin    = sdo_q;
   assign serial_out_oe     = sdo_oe_q;
   assign shift_clock_level = sck_q;
   assign shift_clock_oe    = sck_oe_q;
   assign frame_sync_pulse  = fs_q;
   assign frame_sync_oe     = fs_oe_q;
   assign port_irq          = irq_q;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_word_count_end: assert property (done |-> cnt_q == nbits - 5'h01)
      else $error("word ended at wrong bit count");
   a_irq_flag_set: assert property (done |=> irqf_q)
      else $error("completion did not set the flag");
   a_irq_out_raise: assert property (done && ie_q && !wr |=> port_irq)
      else $error("enabled completion did not raise irq");
   a_rx_copy_word: assert property (done && !rbf_q && !abort |=> rbf_q && rxb_q[7:0] == $past(shifted[7:0]))
      else $error("received word not copied");
   a_overflow_drop: assert property (done && rbf_q && !rbuf |=> rov_q && $stable(rxb_q))
      else $error("overflow did not keep the old word");
   a_overflow_freeze: assert property (rov_q && !rbuf && !abort |=> $stable(cnt_q) && $stable(sr_q) && st_q != ST_DATA)
      else $error("shifting while overflowed");
   a_master_start: assert property (st_q == ST_IDLE && start && ctrl_q.master_enable && !abort |=> st_q != ST_IDLE && sdo_q == spp_word_msb($past(txb_q), ctrl_q.word_size_select))
      else $error("master did not start with the msb");
   a_sleep_abort: assert property (sleep_req |=> st_q == ST_IDLE && cnt_q == 5'h00 ##1 st_q == ST_IDLE || !sleep_req)
      else $error("sleep did not abort the transfer");
   a_desel_reset: assert property (!ctrl_q.master_enable && !ctrl_q.framed_enable && ctrl_q.select_pin_enable && select_n_pin |=> st_q == ST_IDLE && cnt_q == 5'h00)
      else $error("select high did not reset the engine");
   a_out_disable: assert property (ctrl_q.out_pin_disable |=> !serial_out_oe)
      else $error("serial output driven while disabled");

endmodule

`default_nettype wire

// ### tb/spp_peer_model.sv
/*
 far-side serial peripheral model, clocked by the port in master mode
 or by the bench in slave mode.
 assumes the shift clock changes no faster than every second ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module spp_peer_model
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        sclk,
   input  wire logic        pol,
   input  wire logic        cke,
   input  wire logic        sdo,
   output logic             sdi,
   output logic      [15:0] rx,
   output int               nedge,
   output int               half
);
   logic [15:0] tx;
   logic        lvl_q;
   int          idx;
   int          run;

   // ------------------------------------------------------------------
   // word to send on the next frame
   // ------------------------------------------------------------------
   task automatic load(input logic [15:0] w, input int bits);
      tx  = w;
      sdi = w[bits - 1];
      idx = bits - 1 - int'(cke);
   endtask

   // ------------------------------------------------------------------
   // shift on the port's clock edges
   // ------------------------------------------------------------------
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lvl_q <= 1'b0;
         run   <= 0;
         half  <= 0;
         nedge <= 0;
         sdi   <= 1'b0;
         rx    <= 16'h0000;
      end
      else
      begin
         lvl_q <= sclk;
         run   <= run + 1;
         if (sclk !== lvl_q)
         begin
            half <= run;
            run  <= 1;
            if ((sclk !== pol) ^ cke)
            begin
               if (idx >= 0)
               begin
                  sdi <= tx[idx]; // launch edge drives next bit, msb first
               end
               idx <= idx - 1;
            end
            else
            begin
               rx    <= {rx[14:0], sdo}; // capture edge samples
               nedge <= nedge + 1;
            end
         end
      end
   end
endmodule

`default_nettype wire

// ### tb/tb_top.sv
/*
 testbench for the serial peripheral port in master and slave mode.
 assumes the apb slave and the peer model on the serial pins.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import spp_pkg::*;

   localparam logic [11:0] ST = SPP_STAT_OFS;
   localparam logic [11:0] CT = SPP_CTRL_OFS;
   localparam logic [11:0] BF = SPP_BUF_OFS;

   logic        ref_clk;
   logic        rst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        sleep_req;
   logic        pol;
   logic        sdi;
   logic        sdo;
   logic        sdo_oe;
   logic        sclk;
   logic        irq;
   logic        cke;
   logic        slave;
   logic        sck_in;
   logic        ss_n;
   logic        sck_oe;
   logic        oe_mid;
   logic        er;
   logic [31:0] rd;
   logic [15:0] prx;
   int          pn;
   int          ph;
   int          base;
   int          err_total;
   int          n_checks;

   spp_port u_spp_port
   (
      .ref_clk          (ref_clk),
      .rst_n            (rst_n),
      .psel             (psel),
      .penable          (penable),
      .pwrite           (pwrite),
      .paddr            (paddr),
      .pwdata           (pwdata),
      .prdata           (prdata),
      .pready           (pready),
      .pslverr          (pslverr),
      .sleep_req        (sleep_req),
      .idle_req         (1'b0),
      .serial_in_pin    (sdi),
      .serial_out_pin   (sdo),
      .serial_out_oe    (sdo_oe),
      .shift_clock_pin  (sck_in),
      .shift_clock_level(sclk),
      .shift_clock_oe   (sck_oe),
      .select_n_pin     (ss_n),
      .frame_sync_pulse (),
      .frame_sync_oe    (),
      .port_irq         (irq)
   );

   spp_peer_model u_spp_peer_model
   (
      .ref_clk(ref_clk),
      .rst_n  (rst_n),
      .sclk   (slave ? sck_in : sclk),
      .pol    (pol),
      .cke    (cke),
      .sdo    (sdo),
      .sdi    (sdi),
      .rx     (prx),
      .nedge  (pn),
      .half   (ph)
   );

   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // ------------------------------------------------------------------
   // checks and bus tasks
   // ------------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      if (g !== e)
      begin
         $display("BAD %0t got %h exp %h", $time, g, e);
         err_total++;
      end
      n_checks++;
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
         chk(32'(pready), 32'h1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_bits(input int bits);
      int n;
      n = 0;
      while (pn < base + bits && n < 2000)
      begin
         @(posedge ref_clk);
         n++;
         if (pn == base + 2)
            oe_mid = sdo_oe;
      end
      if (n >= 2000)
         chk(pn, base + bits);
      repeat (4) @(posedge ref_clk);
   endtask

   task automatic xfer(input logic [15:0] w, input logic [15:0] pw, input int bits);
      u_spp_peer_model.load(pw, bits);
      base = pn;
      apb(1'b1, BF, 32'(w));
      wait_bits(bits);
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      #200000;
      err_total++;
      report_and_stop();
   end

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial
   begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      sleep_req = 1'b0;
      pol = 1'b0;
      cke = 1'b0;
      slave = 1'b0;
      sck_in = 1'b0;
      ss_n = 1'b1;
      err_total = 0;
      n_checks = 0;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      apb(1'b0, ST, 32'h0); chk(rd, 32'h0);
      apb(1'b0, CT, 32'h0); chk(rd, 32'h0);
      apb(1'b0, 12'h00c, 32'h0); chk(32'(er), 32'h1);
      chk(32'(sclk), 32'h0);
      apb(1'b1, CT, 32'h3b);
      apb(1'b1, ST, 32'h8200);
      xfer(16'h00a5, 16'h003c, 8); chk(32'(prx[7:0]), 32'ha5);
      chk(ph, 2);
      chk(32'(sck_oe), 32'h1);
      chk(32'(irq), 32'h1);
      apb(1'b0, ST, 32'h0); chk(rd, 32'h8301);
      apb(1'b0, BF, 32'h0); chk(rd, 32'h3c);
      apb(1'b0, ST, 32'h0); chk(rd, 32'h8300);
      apb(1'b1, ST, 32'h8100);
      @(posedge ref_clk);
      chk(32'(irq), 32'h0);
      xfer(16'h0011, 16'h0022, 8);
      xfer(16'h0033, 16'h0044, 8);
      apb(1'b0, ST, 32'h0); chk(rd & 32'h41, 32'h41);
      u_spp_peer_model.load(16'h0066, 8);
      base = pn;
      apb(1'b1, BF, 32'h55);
      repeat (40) @(posedge ref_clk);
      chk(pn, base);
      apb(1'b0, BF, 32'h0); chk(rd, 32'h22);
      wait_bits(8); chk(32'(prx[7:0]), 32'h55);
      apb(1'b0, BF, 32'h0); chk(rd, 32'h66);
      apb(1'b1, ST, 32'h0);
      apb(1'b1, CT, 32'h43b);
      apb(1'b1, ST, 32'h8200);
      apb(1'b0, ST, 32'h0); chk(rd, 32'h8200);
      xfer(16'h1234, 16'hbeef, 16); chk(32'(prx), 32'h1234);
      apb(1'b0, BF, 32'h0); chk(rd, 32'hbeef);
      apb(1'b1, ST, 32'h0);
      pol <= 1'b1;
      cke <= 1'b1;
      apb(1'b1, CT, 32'h97b);
      apb(1'b1, ST, 32'h8200);
      @(posedge ref_clk);
      chk(32'(sclk), 32'h1);
      xfer(16'h000f, 16'h005a, 8); chk(32'(oe_mid), 32'h0);
      apb(1'b0, BF, 32'h0); chk(rd, 32'h5a);
      apb(1'b1, ST, 32'h0);
      pol <= 1'b0;
      cke <= 1'b0;
      slave <= 1'b1;
      apb(1'b1, CT, 32'h80);
      apb(1'b1, ST, 32'h8000);
      @(posedge ref_clk);
      chk(32'(sdo_oe), 32'h0);
      chk(32'(sck_oe), 32'h0);
      u_spp_peer_model.load(16'h00c3, 8);
      apb(1'b1, BF, 32'h96);
      ss_n <= 1'b0;
      repeat (16)
      begin
         repeat (4) @(posedge ref_clk);
         sck_in <= ~sck_in;
      end
      repeat (6) @(posedge ref_clk);
      chk(32'(prx[7:0]), 32'h96);
      chk(32'(sdo_oe), 32'h1);
      apb(1'b0, BF, 32'h0); chk(rd, 32'hc3);
      ss_n <= 1'b1;
      slave <= 1'b0;
      apb(1'b1, ST, 32'h0);
      pol <= 1'b0;
      apb(1'b1, CT, 32'h3b);
      apb(1'b1, ST, 32'h8000);
      u_spp_peer_model.load(16'h0000, 8);
      apb(1'b1, BF, 32'h77);
      repeat (6) @(posedge ref_clk);
      sleep_req <= 1'b1;
      repeat (2) @(posedge ref_clk);
      base = pn;
      repeat (40) @(posedge ref_clk);
      chk(pn, base);
      chk(32'(sclk), 32'h0);
      apb(1'b0, CT, 32'h0); chk(rd, 32'h3b);
      sleep_req <= 1'b0;
      report_and_stop();
   end
endmodule

`default_nettype wire
